/* File: hw/mas_map.vh */
/*
 * constants for the memory address source select block: address field
 * positions, slot codes, base register selects and port numbers.
 * assumes it is included by its bare name from the design file.
 */
`ifndef MAS_MAP_VH
`define MAS_MAP_VH

`define MAS_ADDR_W        16
`define MAS_REF_W         6
`define MAS_REF_HI        5
`define MAS_PREV_LO       6
`define MAS_BYTE_W        8
`define MAS_ADDR_HI       15
`define MAS_LO_HI         7
`define MAS_HI_LO         8

// access slot kinds presented by the sequencer
`define MAS_SLOT_CPU      2'h0
`define MAS_SLOT_DMAREF   2'h1
`define MAS_SLOT_THIRD    2'h2
`define MAS_SLOT_IDLE     2'h3

// base register selects
`define MAS_BASE_PC       2'h0
`define MAS_BASE_DC       2'h1
`define MAS_BASE_SPC      2'h2
`define MAS_BASE_IO       2'h3

// i/o port numbers for the two address-line ports
`define MAS_PORT_C        8'h0c
`define MAS_PORT_C_ALT    8'hec
`define MAS_PORT_D        8'h0d
`define MAS_PORT_D_ALT    8'hed

`define MAS_ONES_BYTE     8'hff
`define MAS_ADDR_RST      16'h0000

`endif

/* File: hw/mas_select.v */
/*
 * memory address source select: chooses what the device drives on its
 * sixteen address lines in each access slot, flags the slot's use, and
 * drives the bus read enable and register drive controls.
 * assumes slot, refresh and control inputs come from logic on CLK;
 * external buffer/latches carry ram data to the system bus.
 */
`timescale 1ns/1ps
`include "mas_map.vh"

module mas_select #(
   parameter ADDR_W = `MAS_ADDR_W,
   parameter REF_W  = `MAS_REF_W,
   parameter BYTE_W = `MAS_BYTE_W
) (
   CLK,
   ARST_N,
   SLOT_KIND,
   BASE_SEL,
   REFRESH,
   REFRESH_ADDR,
   DMA_ENABLE,
   RAM_SOURCE,
   REG_BYTE_REQ,
   REG_DRIVE_PERMIT,
   PROGRAM_COUNTER,
   DATA_COUNTER,
   STACK_PROGRAM_COUNTER,
   IO_PORT_NUM,
   PORT_C_DATA,
   PORT_D_DATA,
   ADDR_OUT,
   ADDR_OE,
   PROCESSOR_SLOT,
   MEMORY_IDLE,
   BUS_READ_ENABLE,
   REGISTER_DRIVE,
   DMA_GRANT
);
   input  wire                  CLK;
   input  wire                  ARST_N;
   input  wire [1:0]            SLOT_KIND;
   input  wire [1:0]            BASE_SEL;
   input  wire                  REFRESH;
   input  wire [REF_W-1:0]      REFRESH_ADDR;
   input  wire                  DMA_ENABLE;
   input  wire                  RAM_SOURCE;
   input  wire                  REG_BYTE_REQ;
   input  wire                  REG_DRIVE_PERMIT;
   input  wire [ADDR_W-1:0]     PROGRAM_COUNTER;
   input  wire [ADDR_W-1:0]     DATA_COUNTER;
   input  wire [ADDR_W-1:0]     STACK_PROGRAM_COUNTER;
   input  wire [BYTE_W-1:0]     IO_PORT_NUM;
   input  wire [BYTE_W-1:0]     PORT_C_DATA;
   input  wire [BYTE_W-1:0]     PORT_D_DATA;
   output wire [ADDR_W-1:0]     ADDR_OUT;
   output wire                  ADDR_OE;
   output wire                  PROCESSOR_SLOT;
   output wire                  MEMORY_IDLE;
   output wire                  BUS_READ_ENABLE;
   output wire                  REGISTER_DRIVE;
   output wire                  DMA_GRANT;

   wire [ADDR_W-1:0]  addr_reg;
   reg  [ADDR_W-1:0]  addr_next;
   wire               oe_reg;
   reg                oe_next;
   wire               cpu_slot_reg;
   reg                cpu_slot_next;
   wire               idle_reg;
   reg                idle_next;
   wire               rd_en_reg;
   reg                rd_en_next;
   wire               regdrv_reg;
   reg                regdrv_next;
   wire               grant_reg;
   reg                grant_next;
   wire               prev_refresh_reg;
   reg                prev_refresh_next;
   reg  [ADDR_W-1:0]  base_value;
   reg  [ADDR_W-1:0]  io_value;

   // i/o address formed from the selected port
   always @* begin
      if (IO_PORT_NUM == `MAS_PORT_C || IO_PORT_NUM == `MAS_PORT_C_ALT) begin
         io_value = {PORT_C_DATA, `MAS_ONES_BYTE};
      end else if (IO_PORT_NUM == `MAS_PORT_D || IO_PORT_NUM == `MAS_PORT_D_ALT) begin
         io_value = {`MAS_ONES_BYTE, PORT_D_DATA};
      end else begin
         io_value = PROGRAM_COUNTER;
      end
   end

   always @* begin
      case (BASE_SEL)
         `MAS_BASE_PC:  base_value = PROGRAM_COUNTER;
         `MAS_BASE_DC:  base_value = DATA_COUNTER;
         `MAS_BASE_SPC: base_value = STACK_PROGRAM_COUNTER;
         default:       base_value = io_value;
      endcase
   end

   // address lines and their enable for the coming slot
   always @* begin
      addr_next = addr_reg;
      oe_next   = 1'h1;
      case (SLOT_KIND)
         `MAS_SLOT_CPU: begin
            addr_next = base_value;
         end
         `MAS_SLOT_DMAREF: begin
            if (REFRESH) begin
               // refresh row on the low lines, earlier value kept above it
               addr_next = {addr_reg[ADDR_W-1:REF_W], REFRESH_ADDR};
            end else if (DMA_ENABLE) begin
               oe_next = 1'h0;
            end else begin
               addr_next = base_value;
            end
         end
         `MAS_SLOT_THIRD: begin
            if (prev_refresh_reg) begin
               addr_next = addr_reg;
            end else if (DMA_ENABLE) begin
               oe_next = 1'h0;
            end else begin
               addr_next = base_value;
            end
         end
         default: begin
            oe_next = oe_reg;
         end
      endcase
   end

   // slot use flags and the dma grant
   always @* begin
      cpu_slot_next = 1'h1;
      idle_next     = 1'h0;
      grant_next    = 1'h0;
      case (SLOT_KIND)
         `MAS_SLOT_CPU: begin
            cpu_slot_next = 1'h1;
            idle_next     = 1'h0;
         end
         `MAS_SLOT_DMAREF: begin
            cpu_slot_next = 1'h0;
            if (REFRESH) begin
               idle_next = 1'h0;
            end else if (DMA_ENABLE) begin
               idle_next  = 1'h1;
               grant_next = 1'h1;
            end else begin
               idle_next = 1'h1;
            end
         end
         `MAS_SLOT_THIRD: begin
            // the third slot may float for dma but never grants it
            cpu_slot_next = 1'h0;
            idle_next     = 1'h1;
            grant_next    = 1'h0;
         end
         default: begin
            cpu_slot_next = cpu_slot_reg;
            idle_next     = idle_reg;
         end
      endcase
   end

   // enables for the external buffers only; ram data never passes here
   always @* begin
      rd_en_next  = RAM_SOURCE;
      regdrv_next = REG_BYTE_REQ & REG_DRIVE_PERMIT;
   end

   // remembers whether the last dma/refresh slot refreshed; a processor slot clears it
   always @* begin
      case (SLOT_KIND)
         `MAS_SLOT_DMAREF: prev_refresh_next = REFRESH;
         `MAS_SLOT_CPU:    prev_refresh_next = 1'h0;
         default:          prev_refresh_next = prev_refresh_reg;
      endcase
   end

   mas_dff #(
      .WIDTH   (ADDR_W),
      .RST_VAL (`MAS_ADDR_RST)
   ) addr_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (addr_next),
      .q      (addr_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) oe_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (oe_next),
      .q      (oe_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) cpu_slot_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (cpu_slot_next),
      .q      (cpu_slot_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) idle_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (idle_next),
      .q      (idle_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) rd_en_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (rd_en_next),
      .q      (rd_en_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) regdrv_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (regdrv_next),
      .q      (regdrv_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) grant_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (grant_next),
      .q      (grant_reg)
   );

   mas_dff #(
      .WIDTH   (1),
      .RST_VAL (1'h0)
   ) prev_refresh_dff_i (
      .clk    (CLK),
      .arst_n (ARST_N),
      .d      (prev_refresh_next),
      .q      (prev_refresh_reg)
   );

   assign ADDR_OUT        = addr_reg;
   assign ADDR_OE         = oe_reg;
   assign PROCESSOR_SLOT  = cpu_slot_reg;
   assign MEMORY_IDLE     = idle_reg;
   assign BUS_READ_ENABLE = rd_en_reg;
   assign REGISTER_DRIVE  = regdrv_reg;
   assign DMA_GRANT       = grant_reg;

endmodule

// one register stage with asynchronous active-low reset to a fixed value
module mas_dff #(
   parameter             WIDTH   = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'h0}}
) (
   clk,
   arst_n,
   d,
   q
);
   input  wire              clk;
   input  wire              arst_n;
   input  wire [WIDTH-1:0]  d;
   output wire [WIDTH-1:0]  q;

   reg  [WIDTH-1:0]  q_reg;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q_reg <= RST_VAL;
      end else begin
         q_reg <= d;
      end
   end

   assign q = q_reg;

endmodule

/* File: verification/mas_cpu_model.sv */
/* processor-side model: bus latch strobed by processor slot; assumes CLK is the bus clock */
`timescale 1ns/1ps
module mas_cpu_model(
   input wire        CLK,
   input wire        PROCESSOR_SLOT,
   input wire [15:0] BUS_IN,
   output reg [15:0] LATCHED);
   initial LATCHED = 16'h0000;
   always @(posedge CLK) if (PROCESSOR_SLOT) LATCHED <= BUS_IN;
endmodule

/* File: verification/mas_select_chk_assertions.sv */
/* checker for mas_select; bound to it, sees its ports only */
`timescale 1ns/1ps
module mas_select_chk(
   input wire CLK, ARST_N, REFRESH, DMA_ENABLE, RAM_SOURCE, REG_BYTE_REQ, REG_DRIVE_PERMIT,
   input wire [1:0] SLOT_KIND, BASE_SEL,
   input wire [5:0] REFRESH_ADDR,
   input wire [15:0] PROGRAM_COUNTER, DATA_COUNTER, STACK_PROGRAM_COUNTER, ADDR_OUT,
   input wire [7:0] IO_PORT_NUM, PORT_C_DATA, PORT_D_DATA,
   input wire ADDR_OE, PROCESSOR_SLOT, MEMORY_IDLE, BUS_READ_ENABLE, REGISTER_DRIVE, DMA_GRANT);
   wire io_c = IO_PORT_NUM == 8'h0c || IO_PORT_NUM == 8'hec;
   wire io_d = IO_PORT_NUM == 8'h0d || IO_PORT_NUM == 8'hed;
   wire [15:0] io_v = io_c ? {PORT_C_DATA, 8'hff} : io_d ? {8'hff, PORT_D_DATA} : PROGRAM_COUNTER;
   wire [15:0] base_v = BASE_SEL == 2'h1 ? DATA_COUNTER : BASE_SEL == 2'h2 ?
      STACK_PROGRAM_COUNTER : BASE_SEL == 2'h3 ? io_v : PROGRAM_COUNTER;
   wire plain = SLOT_KIND == 2'h1 && !REFRESH;
   wire reg_req = REG_BYTE_REQ && REG_DRIVE_PERMIT;
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_ref3; SLOT_KIND == 2'h1 && REFRESH ##1 SLOT_KIND == 2'h2; endsequence
   sequence s_dma3; plain && DMA_ENABLE ##1 SLOT_KIND == 2'h2 && DMA_ENABLE; endsequence
   a_read_enable: assert property (1'b1 |=> BUS_READ_ENABLE == $past(RAM_SOURCE))
      else $error("read enable");
   a_reg_drive: assert property (1'b1 |=> REGISTER_DRIVE == $past(reg_req))
      else $error("register drive");
   a_refresh_addr: assert property (SLOT_KIND == 2'h1 && REFRESH |=> ADDR_OE &&
      {ADDR_OUT[15:6], PROCESSOR_SLOT, MEMORY_IDLE} == {$past(ADDR_OUT[15:6]), 2'b00} &&
      ADDR_OUT[5:0] == $past(REFRESH_ADDR)) else $error("refresh address");
   a_full_base: assert property (plain && !DMA_ENABLE |=>
      ADDR_OE && ADDR_OUT == $past(base_v)) else $error("base value");
   a_dma_float: assert property (plain && DMA_ENABLE |=>
      !ADDR_OE && DMA_GRANT && MEMORY_IDLE && !PROCESSOR_SLOT) else $error("dma float");
   a_third_hold: assert property (s_ref3 |=> ADDR_OE && $stable(ADDR_OUT))
      else $error("third hold");
   a_third_float: assert property (s_dma3 |=> !ADDR_OE && !DMA_GRANT)
      else $error("third float");
   a_cpu_slot: assert property (SLOT_KIND == 2'h0 && BASE_SEL == 2'h0 |=>
      PROCESSOR_SLOT && !MEMORY_IDLE && ADDR_OUT == $past(PROGRAM_COUNTER)) else $error("cpu");
endmodule
bind mas_select mas_select_chk mas_select_chk_i (
   .CLK                   (CLK),
   .ARST_N                (ARST_N),
   .REFRESH               (REFRESH),
   .DMA_ENABLE            (DMA_ENABLE),
   .RAM_SOURCE            (RAM_SOURCE),
   .REG_BYTE_REQ          (REG_BYTE_REQ),
   .REG_DRIVE_PERMIT      (REG_DRIVE_PERMIT),
   .SLOT_KIND             (SLOT_KIND),
   .BASE_SEL              (BASE_SEL),
   .REFRESH_ADDR          (REFRESH_ADDR),
   .PROGRAM_COUNTER       (PROGRAM_COUNTER),
   .DATA_COUNTER          (DATA_COUNTER),
   .STACK_PROGRAM_COUNTER (STACK_PROGRAM_COUNTER),
   .ADDR_OUT              (ADDR_OUT),
   .IO_PORT_NUM           (IO_PORT_NUM),
   .PORT_C_DATA           (PORT_C_DATA),
   .PORT_D_DATA           (PORT_D_DATA),
   .ADDR_OE               (ADDR_OE),
   .PROCESSOR_SLOT        (PROCESSOR_SLOT),
   .MEMORY_IDLE           (MEMORY_IDLE),
   .BUS_READ_ENABLE       (BUS_READ_ENABLE),
   .REGISTER_DRIVE        (REGISTER_DRIVE),
   .DMA_GRANT             (DMA_GRANT));

/* File: verification/mas_select_tb.sv */
/* bench for mas_select with processor latch model; needs checker bound */
`timescale 1ns/1ps
module mas_select_tb;
   reg CLK = 1'b0, ARST_N = 1'b0, REFRESH = 1'b0, DMA_ENABLE = 1'b0, RAM_SOURCE = 1'b0;
   reg REG_BYTE_REQ = 1'b0, REG_DRIVE_PERMIT = 1'b0;
   reg [1:0] SLOT_KIND = 2'h3, BASE_SEL = 2'h0;
   reg [5:0] REFRESH_ADDR = 6'h2a;
   reg [15:0] PROGRAM_COUNTER = 16'h1234, DATA_COUNTER = 16'h5678, STACK_PROGRAM_COUNTER = 16'h9abc;
   reg [7:0] IO_PORT_NUM = 8'h00, PORT_C_DATA = 8'ha5, PORT_D_DATA = 8'h3c;
   wire [15:0] ADDR_OUT, latched;
   wire ADDR_OE, PROCESSOR_SLOT, MEMORY_IDLE, BUS_READ_ENABLE, REGISTER_DRIVE, DMA_GRANT;
   wire [5:0] fl = {ADDR_OE, PROCESSOR_SLOT, MEMORY_IDLE, DMA_GRANT, BUS_READ_ENABLE, REGISTER_DRIVE};
   integer failures = 0, comparisons = 0, i;
   mas_select mas_select_i (.CLK(CLK), .ARST_N(ARST_N), .SLOT_KIND(SLOT_KIND),
      .BASE_SEL(BASE_SEL), .REFRESH(REFRESH), .REFRESH_ADDR(REFRESH_ADDR),
      .DMA_ENABLE(DMA_ENABLE), .RAM_SOURCE(RAM_SOURCE), .REG_BYTE_REQ(REG_BYTE_REQ),
      .REG_DRIVE_PERMIT(REG_DRIVE_PERMIT), .PROGRAM_COUNTER(PROGRAM_COUNTER),
      .DATA_COUNTER(DATA_COUNTER), .STACK_PROGRAM_COUNTER(STACK_PROGRAM_COUNTER),
      .IO_PORT_NUM(IO_PORT_NUM), .PORT_C_DATA(PORT_C_DATA), .PORT_D_DATA(PORT_D_DATA),
      .ADDR_OUT(ADDR_OUT), .ADDR_OE(ADDR_OE), .PROCESSOR_SLOT(PROCESSOR_SLOT),
      .MEMORY_IDLE(MEMORY_IDLE), .BUS_READ_ENABLE(BUS_READ_ENABLE),
      .REGISTER_DRIVE(REGISTER_DRIVE), .DMA_GRANT(DMA_GRANT));
   mas_cpu_model mas_cpu_model_i (.CLK(CLK), .PROCESSOR_SLOT(PROCESSOR_SLOT), .BUS_IN(ADDR_OUT),
      .LATCHED(latched));
   initial forever #2.5 CLK = ~CLK;
   task chk(input [15:0] e, input [15:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task chf(input [5:0] e, input [5:0] g);
      chk({10'h000, e}, {10'h000, g});
   endtask
   task go(input [1:0] k, input [1:0] b, input r, input d);
      SLOT_KIND = k;
      BASE_SEL = b;
      REFRESH = r;
      DMA_ENABLE = d;
      @(negedge CLK);
   endtask
   task t_refresh;
      go(2'h0, 2'h0, 1'b0, 1'b0);
      chf(6'b110000, fl);
      PROGRAM_COUNTER = 16'hfff0;
      go(2'h1, 2'h0, 1'b1, 1'b0);
      chk(16'h122a, ADDR_OUT);
      chf(6'b100000, fl);
      chk(16'h1234, latched);
      go(2'h2, 2'h0, 1'b0, 1'b0);
      chk(16'h122a, ADDR_OUT);
   endtask
   task t_base;
      for (i = 0; i < 6; i = i + 1) begin
         go(2'h1 + i[0], i[2:1], 1'b0, 1'b0);
         chk(i < 2 ? 16'hfff0 : i < 4 ? 16'h5678 : 16'h9abc, ADDR_OUT);
      end
   endtask
   task t_dma;
      go(2'h1, 2'h0, 1'b0, 1'b1);
      chf(6'b001100, fl);
      go(2'h2, 2'h0, 1'b0, 1'b1);
      chf(6'b000000, fl & 6'b100100);
   endtask
   task t_io;
      for (i = 0; i < 5; i = i + 1) begin
         IO_PORT_NUM = i == 0 ? 8'h0c : i == 1 ? 8'hec : i == 2 ? 8'h0d : i == 3 ? 8'hed : 8'h0e;
         go(2'h1, 2'h3, 1'b0, 1'b0);
         chk(i < 2 ? 16'ha5ff : i < 4 ? 16'hff3c : 16'hfff0, ADDR_OUT);
      end
   endtask
   task t_data;
      RAM_SOURCE = 1'b1;
      REG_BYTE_REQ = 1'b1;
      go(2'h0, 2'h0, 1'b0, 1'b0);
      chf(6'b000010, fl & 6'b000011);
      RAM_SOURCE = 1'b0;
      REG_DRIVE_PERMIT = 1'b1;
      go(2'h0, 2'h0, 1'b0, 1'b0);
      chf(6'b000001, fl & 6'b000011);
   endtask
   task t_hold;
      go(2'h3, 2'h0, 1'h0, 1'h0);
      chk(16'hfff0, ADDR_OUT);
      chf(6'h31, fl);
      go(2'h1, 2'h0, 1'h0, 1'h1);
      chf(6'h0d, fl);
      go(2'h3, 2'h0, 1'h0, 1'h1);
      chf(6'h09, fl);
   endtask
   task give_verdict;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge CLK);
      chk(16'h0000, {ADDR_OUT[15:6], fl});
      ARST_N = 1'b1;
      t_refresh;
      t_base;
      t_dma;
      t_io;
      t_data;
      t_hold;
      give_verdict;
   end
   initial begin
      #2000;
      failures = failures + 1;
      give_verdict;
   end
endmodule
